//--- logic/lob_core.v
// Network termination overhead bits and activation machine with APB registers
//
// Overview of operation
// [RULE_01] Test-mode flag goes in overhead bit of frame four toward network.
// [RULE_02] Test-mode flag reads one for normal, zero in test mode.
// [RULE_03] Local customer maintenance on D or either B means test mode.
// [RULE_04] Without test-mode function, that bit stays one in operational signal.
// [RULE_05] Cold-start-only flag goes in overhead bit of frame five.
// [RULE_06] Cold-start-only flag is one for cold-start-only transceiver, else zero.
// [RULE_07] Line termination sends activation request in its frame seven bit.
// [RULE_08] Request one asks user side activation; zero keeps it deactivated. The code only reports the bit in the status word; startup does not wait on it.
// [RULE_09] Unused request function means line termination sends one.
// [RULE_10] User-side activity flag goes in overhead bit of frame seven.
// [RULE_11] Activity flag is one while INFO 1 or INFO 3 present.
// [RULE_12] Unused activity function keeps that bit at one.
// [RULE_13] Network side sends path alarm flag in frame eight bit.
// [RULE_14] Path alarm may be one once path reaches the exchange.
// [RULE_15] Intermediate failure forces path alarm flag to zero.
// [RULE_16] Unused path alarm function holds the bit at one.
// [RULE_17] Converged plus sync and phase two detected enters sync, sends phase two.
// [RULE_18] Each activation state drives its documented line signal.
// [RULE_19] Power-on starts startup timer, enters alerting; power loss returns off.
// [RULE_20] After 9 ms tone, train or converge; convergence moves to converged.
// [RULE_21] Inverted sync stops startup timer; far tone in receive-reset re-alerts.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "lob_consts.vh"

module lob_core #(
    parameter TONE_CYCLES = (`LOB_TONE_US * `LOB_CLK_MHZ)
)(
    // Clock, reset, enable
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Receiver and transceiver status pins
    input wire power_ok_in,
    input wire lt_wake_tone_in,
    input wire canceller_converged_in,
    input wire frame_word_sync_in,
    input wire lt_second_signal_phase_in,
    input wire inverted_frame_word_sync_in,
    input wire user_info13_in,
    input wire [2:0] rx_frame_in,
    input wire rx_overhead_bit_in,
    input wire [2:0] tx_frame_in,
    // Line outputs
    output reg [2:0] line_signal_out,
    output reg maintenance_overhead_bit_out,
    output reg startup_timer_run_out
);

// ****************************************************************
// Input synchronisers
// ****************************************************************
// Bits are synchronised one by one: frame numbers must change one bit at a time
// or stay stable for several clocks around each change
wire [6:0] lvl_sync_w;
wire [3:0] rx_sync_w;
wire [2:0] tx_sync_w;
lob_sync2 #(
    .WIDTH(7)
) u_lvl_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .raw_in({power_ok_in, lt_wake_tone_in, canceller_converged_in, frame_word_sync_in,
             lt_second_signal_phase_in, inverted_frame_word_sync_in, user_info13_in}),
    .sync_out(lvl_sync_w)
);
lob_sync2 #(
    .WIDTH(4),
    .RESET_VALUE(16'h0003)
) u_rx_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .raw_in({rx_frame_in, rx_overhead_bit_in}),
    .sync_out(rx_sync_w)
);
lob_sync2 #(
    .WIDTH(3)
) u_tx_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .raw_in(tx_frame_in),
    .sync_out(tx_sync_w)
);
wire s_power = lvl_sync_w[6];
wire s_tone = lvl_sync_w[5];
wire s_conv = lvl_sync_w[4];
wire s_fws = lvl_sync_w[3];
wire s_ph2 = lvl_sync_w[2];
wire s_ifws = lvl_sync_w[1];
wire s_info13 = lvl_sync_w[0];
wire [2:0] s_rxfr = rx_sync_w[3:1];
wire s_rxbit = rx_sync_w[0];
wire [2:0] s_txfr = tx_sync_w;

// ****************************************************************
// APB registers
// ****************************************************************
reg [5:0] ctrl_q;
reg act_req_q;
reg path_alarm_flag_q;
wire access_w = psel_in & penable_in & ~pready_out;
wire [3:0] state_w;
wire [31:0] ctrl_rst_w = `LOB_CTRL_RESET;
// One wait state: pready rises the cycle after the access phase begins and drops at once,
// so a master that holds the access phase has a second transfer taken two cycles after the first
always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        ctrl_q <= ctrl_rst_w[5:0];
        prdata_out <= 32'h0000_0000;
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
    end
    else if (ce_in)
    begin
        pready_out <= access_w;
        pslverr_out <= 1'b0;
        // Read data stands only while pready is high
        prdata_out <= 32'h0000_0000;
        if (access_w)
        begin
            case (paddr_in)
                `LOB_CTRL_OFS:
                begin
                    if (pwrite_in)
                        ctrl_q <= pwdata_in[5:0];
                    prdata_out <= {26'd0, ctrl_q};
                end
                `LOB_STAT_OFS:
                    prdata_out <= {24'd0, act_req_q, path_alarm_flag_q, 2'd0, state_w};
                `LOB_OHB_OFS:
                    prdata_out <= {31'd0, maintenance_overhead_bit_out};
                // Unmapped offsets answer with an error and write nothing
                default:
                    pslverr_out <= 1'b1;
            endcase
        end
    end
end

// ****************************************************************
// Received overhead bits
// ****************************************************************
// Request and alarm reset to one, matching the "function unused" value
always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        act_req_q <= 1'b1;
        path_alarm_flag_q <= 1'b1;
    end
    else if (ce_in)
    begin
        if (s_rxfr == `LOB_FRAME_SAI)
            act_req_q <= s_rxbit; // [RULE_07] [RULE_08] [RULE_09]
        if (s_rxfr == `LOB_FRAME_AIB)
            path_alarm_flag_q <= s_rxbit; // [RULE_13] [RULE_14] [RULE_15] [RULE_16]
    end
end

// ****************************************************************
// Activation state machine
// ****************************************************************
// Codes are the state numbers software reads in the status word
localparam ST_OFF = 4'd0;
localparam ST_RESET = 4'd1;
localparam ST_ALERT = 4'd2;
localparam ST_TRAIN = 4'd3;
localparam ST_CONV = 4'd4;
localparam ST_FWS = 4'd5;
localparam ST_IFWS = 4'd6;
localparam ST_TEAR = 4'd10;
localparam ST_RXRST = 4'd12;

reg [3:0] state_q;
reg [3:0] state_d;
reg [31:0] tone_cnt_q;
assign state_w = state_q;

always @*
begin
    state_d = state_q;
    // Loss of power overrides every other event
    if (!s_power)
        state_d = ST_OFF; // [RULE_19]
    else
    begin
        case (state_q)
            ST_OFF:
                state_d = ST_ALERT; // [RULE_19]
            ST_RESET:
                if (s_tone)
                    state_d = ST_ALERT;
            ST_ALERT:
                if (tone_cnt_q == TONE_CYCLES - 1)
                    state_d = ctrl_q[`LOB_CTRL_TRAIN] ? ST_TRAIN : ST_CONV; // [RULE_20]
            ST_TRAIN:
                if (s_conv)
                    state_d = ST_CONV; // [RULE_20]
            ST_CONV:
                if (s_fws && s_ph2)
                    state_d = ST_FWS; // [RULE_17]
            ST_FWS:
                if (s_ifws)
                    state_d = ST_IFWS; // [RULE_21]
            ST_IFWS:
                state_d = ST_IFWS;
            ST_TEAR:
                state_d = ST_TEAR;
            ST_RXRST:
                if (s_tone)
                    state_d = ST_ALERT; // [RULE_21]
            default:
                state_d = ST_RESET;
        endcase
    end
end

always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        state_q <= ST_OFF;
        tone_cnt_q <= 32'h0000_0000;
        startup_timer_run_out <= 1'b0;
    end
    else if (ce_in)
    begin
        state_q <= state_d;
        // Count ends at TONE_CYCLES - 1, so the tone lasts exactly TONE_CYCLES clocks
        if (state_q == ST_ALERT && state_d == ST_ALERT)
            tone_cnt_q <= tone_cnt_q + 32'h0000_0001;
        else
            tone_cnt_q <= 32'h0000_0000;
        if (!s_power || (state_q == ST_FWS && s_ifws))
            startup_timer_run_out <= 1'b0; // [RULE_21]
        else if ((state_q == ST_OFF) || (state_q != ST_ALERT && state_d == ST_ALERT))
            startup_timer_run_out <= 1'b1; // [RULE_19]
    end
end

// ****************************************************************
// Line outputs
// ****************************************************************
wire test_mode_flag = ctrl_q[`LOB_CTRL_TM_EN] ? ~ctrl_q[`LOB_CTRL_TM_LOCAL] : 1'b1; // [RULE_02] [RULE_03] [RULE_04]
wire cold_start_only_flag = ctrl_q[`LOB_CTRL_CSO_CAP]; // [RULE_06]
wire user_side_activity_flag = ctrl_q[`LOB_CTRL_SAI_EN] ? s_info13 : 1'b1; // [RULE_11] [RULE_12]
reg [2:0] sig_d;
reg ohb_d;

// Decoding the next state lets the line signal change on the same edge as the state
always @*
begin
    case (state_d)
        ST_OFF: sig_d = `LOB_SIG_SILENCE; // [RULE_18]
        ST_RESET: sig_d = `LOB_SIG_SILENCE; // [RULE_18]
        ST_ALERT: sig_d = `LOB_SIG_TONE; // [RULE_18]
        ST_TRAIN: sig_d = `LOB_SIG_PHASE1; // [RULE_18]
        ST_CONV: sig_d = `LOB_SIG_SILENCE; // [RULE_18]
        ST_FWS: sig_d = `LOB_SIG_PHASE2; // [RULE_17]
        ST_IFWS: sig_d = `LOB_SIG_OPER; // [RULE_18]
        ST_TEAR: sig_d = `LOB_SIG_SILENCE; // [RULE_18]
        ST_RXRST: sig_d = `LOB_SIG_SILENCE; // [RULE_18]
        default: sig_d = `LOB_SIG_SILENCE;
    endcase
end

// Frames other than four, five and seven carry functions left unused here, sent as one
always @*
begin
    case (s_txfr)
        `LOB_FRAME_TM: ohb_d = test_mode_flag; // [RULE_01]
        `LOB_FRAME_CSO: ohb_d = cold_start_only_flag; // [RULE_05]
        `LOB_FRAME_SAI: ohb_d = user_side_activity_flag; // [RULE_10]
        default: ohb_d = 1'b1;
    endcase
end

always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        line_signal_out <= `LOB_SIG_SILENCE;
        maintenance_overhead_bit_out <= 1'b1;
    end
    else if (ce_in)
    begin
        line_signal_out <= sig_d;
        maintenance_overhead_bit_out <= ohb_d;
    end
end

endmodule // lob_core

// ****************************************************************
// Two-flop synchroniser
// ****************************************************************
module lob_sync2 #(
    parameter WIDTH = 1,
    parameter [15:0] RESET_VALUE = 16'h0000
)(
    // Clock, reset, enable
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    // Raw pin value and its synchronised copy
    input wire [WIDTH-1:0] raw_in,
    output reg [WIDTH-1:0] sync_out
);

// Nothing but the second stage reads the first, so a metastable sample never fans out
reg [WIDTH-1:0] meta_q;

always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        meta_q <= RESET_VALUE[WIDTH-1:0];
        sync_out <= RESET_VALUE[WIDTH-1:0];
    end
    else if (ce_in)
    begin
        meta_q <= raw_in;
        sync_out <= meta_q;
    end
end

endmodule // lob_sync2
`default_nettype wire

//--- logic/lob_consts.vh
// Constants for the line overhead bits and activation block
`ifndef LOB_CONSTS_VH
`define LOB_CONSTS_VH
// APB register byte offsets
`define LOB_CTRL_OFS 12'h000
`define LOB_STAT_OFS 12'h004
`define LOB_OHB_OFS 12'h008
// Control register fields
`define LOB_CTRL_ACT_REQ 0
`define LOB_CTRL_TM_EN 1
`define LOB_CTRL_TM_LOCAL 2
`define LOB_CTRL_CSO_CAP 3
`define LOB_CTRL_SAI_EN 4
`define LOB_CTRL_TRAIN 5
`define LOB_CTRL_RESET 32'h0000_0000
// Overhead bit positions inside the multiframe (basic frame numbers)
`define LOB_FRAME_TM 3'd4
`define LOB_FRAME_CSO 3'd5
`define LOB_FRAME_SAI 3'd7
`define LOB_FRAME_AIB 3'd0
// Line signal codes
`define LOB_SIG_SILENCE 3'd0
`define LOB_SIG_TONE 3'd1
`define LOB_SIG_PHASE1 3'd2
`define LOB_SIG_PHASE2 3'd3
`define LOB_SIG_OPER 3'd4
// Timing
`define LOB_CLK_MHZ 100
`define LOB_TONE_US 9000
`endif

//--- logic/lob_unused_placeholder_none.v
// Intentionally empty design companion file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- sim/lob_core_assertions.sv
// Concurrent checks on the activation and overhead bit ports
`timescale 1ns/1ns
`default_nettype none
module lob_core_assertions #(
    parameter TONE_CYCLES = 20
)(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Line status inputs
    input wire logic power_ok_in,
    input wire logic canceller_converged_in,
    input wire logic frame_word_sync_in,
    input wire logic lt_second_signal_phase_in,
    input wire logic inverted_frame_word_sync_in,
    input wire logic [2:0] tx_frame_in,
    // Line outputs
    input wire logic [2:0] line_signal_out,
    input wire logic maintenance_overhead_bit_out,
    input wire logic startup_timer_run_out
);
    // ****
    // Checks
    // ****
    localparam int TLO = TONE_CYCLES - 3;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_sync_gain;
        $rose(frame_word_sync_in && lt_second_signal_phase_in);
    endsequence
    sequence s_inv_gain;
        $rose(inverted_frame_word_sync_in);
    endsequence
    a_power_loss: assert property ($fell(power_ok_in) |-> ##[1:6] line_signal_out == 3'h0 && !startup_timer_run_out)
        else $error("power loss left the line busy");
    a_tone_length: assert property ($rose(line_signal_out == 3'h1) |-> ##TLO line_signal_out == 3'h1 ##[1:6] line_signal_out inside {3'h0, 3'h2})
        else $error("wake tone length wrong");
    a_timer_run: assert property (line_signal_out inside {3'h1, 3'h2, 3'h3} |-> startup_timer_run_out)
        else $error("startup timer idle during startup");
    a_oper_timer: assert property (line_signal_out == 3'h4 |-> !startup_timer_run_out)
        else $error("startup timer runs in operation");
    a_train_conv: assert property (line_signal_out == 3'h2 && $rose(canceller_converged_in) |-> ##[2:6] line_signal_out == 3'h0)
        else $error("training did not end on convergence");
    a_sync_phase: assert property (line_signal_out == 3'h0 && startup_timer_run_out ##0 s_sync_gain |-> ##[2:6] line_signal_out == 3'h3)
        else $error("no second phase after sync");
    a_inv_sync: assert property (line_signal_out == 3'h3 ##0 s_inv_gain |-> ##[2:6] line_signal_out == 3'h4 && !startup_timer_run_out)
        else $error("inverted sync not taken");
    a_spare_ones: assert property (($stable(tx_frame_in) && !(tx_frame_in inside {3'h4, 3'h5, 3'h7}))[*6] |-> maintenance_overhead_bit_out)
        else $error("spare overhead bit not one");
endmodule // lob_core_assertions
bind lob_core lob_core_assertions #(.TONE_CYCLES(TONE_CYCLES)) u_lob_chk (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .power_ok_in(power_ok_in),
    .canceller_converged_in(canceller_converged_in),
    .frame_word_sync_in(frame_word_sync_in),
    .lt_second_signal_phase_in(lt_second_signal_phase_in),
    .inverted_frame_word_sync_in(inverted_frame_word_sync_in),
    .tx_frame_in(tx_frame_in),
    .line_signal_out(line_signal_out),
    .maintenance_overhead_bit_out(maintenance_overhead_bit_out),
    .startup_timer_run_out(startup_timer_run_out)
);
`default_nettype wire

//--- sim/lob_lt_model.sv
// Line termination model feeding frames and sync status
`timescale 1ns/1ns
`default_nettype none
module lob_lt_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Mode 0 quiet, 1 second phase, 2 inverted sync
    input wire logic [1:0] link_in,
    input wire logic act_req_in,
    input wire logic alarm_in,
    // Status toward the block
    output wire logic sync_out,
    output wire logic inv_sync_out,
    output wire logic [2:0] frame_out,
    output wire logic bit_out
);
    // ****
    // Framing
    // ****
    logic [4:0] cnt_q;
    always_ff @(posedge clk_in)
        cnt_q <= resetn_in ? cnt_q + 5'h01 : 5'h00;
    // Four cycles a frame so the block's synchronisers catch each one
    assign frame_out = cnt_q[4:2];
    assign sync_out = link_in != 2'h0;
    assign inv_sync_out = link_in == 2'h2;
    // A quiet line carries no bits, so a toggling pattern stands in
    assign bit_out = link_in == 2'h0 ? cnt_q[0] :
        frame_out == 3'h7 ? act_req_in :
        frame_out == 3'h0 ? alarm_in : 1'b1;
endmodule // lob_lt_model
`default_nettype wire

//--- sim/test_line_overhead_bits_activation.sv
// Self-checking bench for the activation and overhead bit block
`timescale 1ns/1ns
`default_nettype none
`include "lob_consts.vh"
module test_line_overhead_bits_activation;
    // ****
    // Signals
    // ****
    localparam int TONE = 20;
    logic clk_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, q;
    logic pready_out, pslverr_out, e, maintenance_overhead_bit_out, startup_timer_run_out;
    logic power_ok_in = 1'b0, canceller_converged_in = 1'b0, user_info13_in = 1'b0;
    logic ce_in = 1'b1, act_req = 1'b0, alarm = 1'b0;
    logic [2:0] tx_frame_in = 3'h1, line_signal_out;
    logic [1:0] link = 2'h0;
    wire frame_word_sync_in, inverted_frame_word_sync_in, rx_overhead_bit_in;
    wire lt_second_signal_phase_in = frame_word_sync_in;
    wire [2:0] rx_frame_in;
    int fail_count = 0, compares = 0, cycles = 0;
    logic [5:0] rctl [6] = '{6'h00, 6'h02, 6'h06, 6'h08, 6'h10, 6'h10};
    logic rinf [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [2:0] rexp [6] = '{3'h5, 3'h5, 3'h1, 3'h7, 3'h4, 3'h5};
    logic [2:0] fr [3] = '{`LOB_FRAME_TM, `LOB_FRAME_CSO, `LOB_FRAME_SAI};
    lob_core #(.TONE_CYCLES(TONE)) DUT (.*, .ce_in(ce_in), .lt_wake_tone_in(1'b0));
    lob_lt_model u_lt (.clk_in(clk_in), .resetn_in(resetn_in), .link_in(link), .act_req_in(act_req),
        .alarm_in(alarm), .sync_out(frame_word_sync_in), .inv_sync_out(inverted_frame_word_sync_in),
        .frame_out(rx_frame_in), .bit_out(rx_overhead_bit_in));
    initial
        forever #5 clk_in = ~clk_in;
    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        chk("apb ready", 1, pready_out);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wait_ls(input logic [2:0] v);
        int n;
        n = 0;
        while (line_signal_out !== v && n < 500)
        begin
            @(posedge clk_in);
            n++;
        end
        chk("line signal", v, line_signal_out);
    endtask
    task automatic wrap_up;
        $display("Compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            wrap_up;
        end
    end
    // ****
    // Sequence
    // ****
    initial
    begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        chk("line signal", `LOB_SIG_SILENCE, line_signal_out);
        chk("overhead bit", 1, maintenance_overhead_bit_out);
        chk("startup timer", 0, startup_timer_run_out);
        apb(1'b0, `LOB_CTRL_OFS, 0);
        chk("control", `LOB_CTRL_RESET, q);
        apb(1'b0, 12'h00C, 0);
        chk("unmapped error", 1, e);
        $display("reset test done");
        apb(1'b1, `LOB_CTRL_OFS, 32'h0000_0020);
        power_ok_in <= 1'b1;
        wait_ls(`LOB_SIG_TONE);
        chk("startup timer", 1, startup_timer_run_out);
        wait_ls(`LOB_SIG_PHASE1);
        canceller_converged_in <= 1'b1;
        wait_ls(`LOB_SIG_SILENCE);
        link <= 2'h1;
        wait_ls(`LOB_SIG_PHASE2);
        link <= 2'h2;
        wait_ls(`LOB_SIG_OPER);
        chk("startup timer", 0, startup_timer_run_out);
        $display("startup test done");
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `LOB_CTRL_OFS, {26'h000_0000, rctl[i]});
            user_info13_in <= rinf[i];
            for (int f = 0; f < 3; f++)
            begin
                tx_frame_in <= fr[f];
                repeat (6) @(posedge clk_in);
                chk("overhead bit", rexp[i][2-f], maintenance_overhead_bit_out);
            end
        end
        ce_in <= 1'b0;
        tx_frame_in <= `LOB_FRAME_CSO;
        repeat (6) @(posedge clk_in);
        chk("frozen overhead bit", 1, maintenance_overhead_bit_out);
        ce_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("overhead bit", 0, maintenance_overhead_bit_out);
        apb(1'b0, `LOB_STAT_OFS, 0);
        chk("state and flags", 6'h06, {q[7:6], q[3:0]});
        act_req <= 1'b1;
        alarm <= 1'b1;
        repeat (40) @(posedge clk_in);
        apb(1'b0, `LOB_STAT_OFS, 0);
        chk("state and flags", 6'h36, {q[7:6], q[3:0]});
        $display("overhead rows done");
        power_ok_in <= 1'b0;
        wait_ls(`LOB_SIG_SILENCE);
        link <= 2'h0;
        apb(1'b1, `LOB_CTRL_OFS, 0);
        power_ok_in <= 1'b1;
        wait_ls(`LOB_SIG_TONE);
        repeat (TONE + 6) @(posedge clk_in);
        chk("direct converge", `LOB_SIG_SILENCE, line_signal_out);
        chk("startup timer", 1, startup_timer_run_out);
        $display("power cycle test done");
        wrap_up;
    end
endmodule // test_line_overhead_bits_activation
`default_nettype wire
